// file: jfrpe_defines.vh
// Purpose: constants for the flash readback / programming entry test-port block
// Assumes: 10 MHz ref_clk, test port sampled as ordinary pins
// Notes: definitions only
`ifndef JFRPE_DEFINES_VH
`define JFRPE_DEFINES_VH

// instruction codes (4-bit instruction register)
`define JFRPE_IR_W 4
`define JFRPE_INSTR_PAGE_READ 4'h7
`define JFRPE_INSTR_CMD_ENTRY 4'h5
`define JFRPE_INSTR_UNLOCK 4'h4
`define JFRPE_INSTR_RESET 4'hc
`define JFRPE_INSTR_BYPASS 4'hf

// programming enable signature, 16 bits
`define JFRPE_UNLOCK_SIG 16'ha370
`define JFRPE_UNLOCK_W 16
`define JFRPE_BYTE_W 8
`define JFRPE_CMD_W 15

// tap state codes (standard 4-bit encoding)
`define JFRPE_TAP_RESET 4'hf
`define JFRPE_TAP_IDLE 4'hc
`define JFRPE_TAP_SEL_DR 4'h7
`define JFRPE_TAP_CAP_DR 4'h6
`define JFRPE_TAP_SHIFT_DR 4'h2
`define JFRPE_TAP_EXIT1_DR 4'h1
`define JFRPE_TAP_PAUSE_DR 4'h3
`define JFRPE_TAP_EXIT2_DR 4'h0
`define JFRPE_TAP_UPD_DR 4'h5
`define JFRPE_TAP_SEL_IR 4'h4
`define JFRPE_TAP_CAP_IR 4'he
`define JFRPE_TAP_SHIFT_IR 4'ha
`define JFRPE_TAP_EXIT1_IR 4'h9
`define JFRPE_TAP_PAUSE_IR 4'hb
`define JFRPE_TAP_EXIT2_IR 4'h8
`define JFRPE_TAP_UPD_IR 4'hd

// reset time-out, in microseconds per clock option, and cycles at 10 MHz
`define JFRPE_CLK_HZ 10000000
`define JFRPE_TOUT_SHORT_US 64
`define JFRPE_TOUT_LONG_US 400
`define JFRPE_TOUT_SHORT_CYC ((`JFRPE_TOUT_SHORT_US * (`JFRPE_CLK_HZ / 1000000)))
`define JFRPE_TOUT_LONG_CYC ((`JFRPE_TOUT_LONG_US * (`JFRPE_CLK_HZ / 1000000)))
`define JFRPE_TOUT_W 16

`endif

// file: jfrpe_skid_buf.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: full and empty are exact; ready in is low only when both slots hold data
module jfrpe_skid_buf #(
    parameter WIDTH = 8,
    parameter DEPTH = 2
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [0:0] wr_ptr_q;
    reg [0:0] rd_ptr_q;
    reg [1:0] count_q;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // storage and pointers; data sits in flops, read side selects
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end
        else
        begin
            if (do_wr)
            begin
                mem_q[wr_ptr_q] <= in_data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (do_rd)
                rd_ptr_q <= ~rd_ptr_q;
            if (do_wr && !do_rd)
                count_q <= count_q + 2'h1;
            else if (do_rd && !do_wr)
                count_q <= count_q - 2'h1;
        end
    end
endmodule // jfrpe_skid_buf

// file: jfrpe_core.v
// Purpose: test-port data registers for flash page readback and programming entry
// Assumes: tck/tms/tdi/trst are slow pins sampled by ref_clk (tck << ref_clk)
// Notes: flash reads go through a request/answer port; words land in a 2-entry buffer
//
// What this block does
// R1: instruction 0x7 selects the 8-bit flash byte register (low byte of the command reg).
// R2: each Capture-DR under page read loads a flash byte, low first, then alternating.
// R3: the program counter advances after every high byte, including the first one.
// R4: in Shift-DR under page read the byte register shifts one bit per tck toward tdo.
// R5: the programmer must assert the reset register before entering programming mode; the block does not check it, prog_mode follows the enable register alone.
// R6: a one in the reset register holds the device in reset for as long as it stays.
// R7: after the reset register clears, reset lasts a fuse-selected time-out.
// R8: the reset register drives the reset line directly, with no update latch.
// R9: a 16-bit enable register unlocks programming only while it equals the signature.
// R10: the enable register clears to zero on power-on reset.
// R11: the programmer should clear the enable register when leaving programming mode.
// R12: at Update-DR under the unlock instruction the value is compared and mode entered.
`include "jfrpe_defines.vh"
module jfrpe_core #(
    parameter ADDR_W = 16,
    parameter TOUT_SHORT_CYC = `JFRPE_TOUT_SHORT_CYC,
    parameter TOUT_LONG_CYC = `JFRPE_TOUT_LONG_CYC
) (
    // clock and power-on reset
    input wire ref_clk,
    input wire rst,
    // test port pins; tdo is three-state, enable low while driving
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trst_n,
    output reg tdo_o,
    output reg tdo_oe_n,
    // program counter preset from the command path
    input wire pc_load,
    input wire [ADDR_W-1:0] pc_load_val,
    output wire [ADDR_W-1:0] prog_counter,
    // flash word read: request held until ack
    output wire flash_rd_req,
    output wire [ADDR_W-1:0] flash_rd_addr,
    input wire flash_rd_ack,
    input wire [15:0] flash_rd_data,
    // status and reset outputs
    input wire clk_fuse_long,
    output wire dev_reset,
    output wire prog_mode,
    output wire [`JFRPE_IR_W-1:0] active_instr
);
    // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
    reg [2:0] tck_s_q, tms_s_q, tdi_s_q, trst_s_q;
    reg tck_f_q, tms_f_q, tdi_f_q, trst_f_q;
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            tck_s_q <= 3'h0;
            tms_s_q <= 3'h7;
            tdi_s_q <= 3'h0;
            trst_s_q <= 3'h7;
            tck_f_q <= 1'b0;
            tms_f_q <= 1'b1;
            tdi_f_q <= 1'b0;
            trst_f_q <= 1'b1;
        end
        else
        begin
            tck_s_q <= {tck_s_q[1:0], tck};
            tms_s_q <= {tms_s_q[1:0], tms};
            tdi_s_q <= {tdi_s_q[1:0], tdi};
            trst_s_q <= {trst_s_q[1:0], trst_n};
            if (tck_s_q[1] == tck_s_q[2])
                tck_f_q <= tck_s_q[2];
            if (tms_s_q[1] == tms_s_q[2])
                tms_f_q <= tms_s_q[2];
            if (tdi_s_q[1] == tdi_s_q[2])
                tdi_f_q <= tdi_s_q[2];
            if (trst_s_q[1] == trst_s_q[2])
                trst_f_q <= trst_s_q[2];
        end
    end

    wire tck_rise = (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_f_q;
    wire tck_fall = (tck_s_q[1] == tck_s_q[2]) && !tck_s_q[2] && tck_f_q;
    wire tap_rst = rst || !trst_f_q;

    // next tap state as a function of state and tms
    function [3:0] tap_next;
        input [3:0] st;
        input m;
        begin
            case (st)
                `JFRPE_TAP_RESET: tap_next = m ? `JFRPE_TAP_RESET : `JFRPE_TAP_IDLE;
                `JFRPE_TAP_IDLE: tap_next = m ? `JFRPE_TAP_SEL_DR : `JFRPE_TAP_IDLE;
                `JFRPE_TAP_SEL_DR: tap_next = m ? `JFRPE_TAP_SEL_IR : `JFRPE_TAP_CAP_DR;
                `JFRPE_TAP_CAP_DR: tap_next = m ? `JFRPE_TAP_EXIT1_DR : `JFRPE_TAP_SHIFT_DR;
                `JFRPE_TAP_SHIFT_DR: tap_next = m ? `JFRPE_TAP_EXIT1_DR : `JFRPE_TAP_SHIFT_DR;
                `JFRPE_TAP_EXIT1_DR: tap_next = m ? `JFRPE_TAP_UPD_DR : `JFRPE_TAP_PAUSE_DR;
                `JFRPE_TAP_PAUSE_DR: tap_next = m ? `JFRPE_TAP_EXIT2_DR : `JFRPE_TAP_PAUSE_DR;
                `JFRPE_TAP_EXIT2_DR: tap_next = m ? `JFRPE_TAP_UPD_DR : `JFRPE_TAP_SHIFT_DR;
                `JFRPE_TAP_UPD_DR: tap_next = m ? `JFRPE_TAP_SEL_DR : `JFRPE_TAP_IDLE;
                `JFRPE_TAP_SEL_IR: tap_next = m ? `JFRPE_TAP_RESET : `JFRPE_TAP_CAP_IR;
                `JFRPE_TAP_CAP_IR: tap_next = m ? `JFRPE_TAP_EXIT1_IR : `JFRPE_TAP_SHIFT_IR;
                `JFRPE_TAP_SHIFT_IR: tap_next = m ? `JFRPE_TAP_EXIT1_IR : `JFRPE_TAP_SHIFT_IR;
                `JFRPE_TAP_EXIT1_IR: tap_next = m ? `JFRPE_TAP_UPD_IR : `JFRPE_TAP_PAUSE_IR;
                `JFRPE_TAP_PAUSE_IR: tap_next = m ? `JFRPE_TAP_EXIT2_IR : `JFRPE_TAP_PAUSE_IR;
                `JFRPE_TAP_EXIT2_IR: tap_next = m ? `JFRPE_TAP_UPD_IR : `JFRPE_TAP_SHIFT_IR;
                `JFRPE_TAP_UPD_IR: tap_next = m ? `JFRPE_TAP_SEL_DR : `JFRPE_TAP_IDLE;
                default: tap_next = `JFRPE_TAP_RESET;
            endcase
        end
    endfunction

    reg [3:0] tap_q;
    reg [`JFRPE_IR_W-1:0] ir_sh_q, ir_q;
    reg [`JFRPE_CMD_W-1:0] cmd_sh_q;
    reg [`JFRPE_UNLOCK_W-1:0] unlock_sh_q, unlock_q;
    reg reset_reg_q;
    reg bypass_q;
    reg hi_sel_q;
    reg [ADDR_W-1:0] pc_q;
    reg [15:0] word_q;
    reg word_ok_q;

    wire sel_read = (ir_q == `JFRPE_INSTR_PAGE_READ); // R1
    wire sel_unlock = (ir_q == `JFRPE_INSTR_UNLOCK);
    wire sel_reset = (ir_q == `JFRPE_INSTR_RESET);
    wire sel_cmd = (ir_q == `JFRPE_INSTR_CMD_ENTRY);
    wire cap_dr = tck_rise && (tap_q == `JFRPE_TAP_CAP_DR);
    wire shift_dr = tck_rise && (tap_q == `JFRPE_TAP_SHIFT_DR);
    wire upd_dr = tck_rise && (tap_q == `JFRPE_TAP_UPD_DR);

    // flash words come back through the buffer; capture never waits, so a word not yet arrived is captured stale
    wire buf_out_valid;
    wire [15:0] buf_out_data;
    wire buf_in_ready;
    wire buf_take = cap_dr && sel_read && !hi_sel_q;
    reg req_q;
    jfrpe_skid_buf #(
        .WIDTH(16),
        .DEPTH(2)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(flash_rd_ack && req_q),
        .in_ready(buf_in_ready),
        .in_data(flash_rd_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_take),
        .out_data(buf_out_data)
    );
    assign flash_rd_req = req_q;
    assign flash_rd_addr = pc_q;

    // prefetch the word at pc while page read is active, the buffer is empty and no low byte awaits its high byte
    always @(posedge ref_clk)
    begin
        if (rst)
            req_q <= 1'b0;
        else if (req_q && flash_rd_ack)
            req_q <= 1'b0;
        else if (sel_read && buf_in_ready && !buf_out_valid && !word_ok_q)
            req_q <= 1'b1;
    end

    // tap state, instruction register and data registers
    always @(posedge ref_clk)
    begin
        if (tap_rst)
        begin
            tap_q <= `JFRPE_TAP_RESET;
            ir_sh_q <= `JFRPE_INSTR_BYPASS;
            ir_q <= `JFRPE_INSTR_BYPASS;
            cmd_sh_q <= 15'h0000;
            unlock_sh_q <= 16'h0000;
            bypass_q <= 1'b0;
            hi_sel_q <= 1'b0;
            word_q <= 16'h0000;
            word_ok_q <= 1'b0;
        end
        else
        begin
            if (tck_rise)
                tap_q <= tap_next(tap_q, tms_f_q);
            if (tck_rise && tap_q == `JFRPE_TAP_CAP_IR)
                ir_sh_q <= 4'h1;
            if (tck_rise && tap_q == `JFRPE_TAP_SHIFT_IR)
                ir_sh_q <= {tdi_f_q, ir_sh_q[`JFRPE_IR_W-1:1]};
            if (tck_rise && tap_q == `JFRPE_TAP_UPD_IR)
            begin
                ir_q <= ir_sh_q;
                hi_sel_q <= 1'b0; // R2
                word_ok_q <= 1'b0; // R2
            end
            // page read capture: low byte from fresh word, then high byte
            if (cap_dr && sel_read)
            begin
                if (!hi_sel_q)
                begin
                    word_q <= buf_out_data;
                    cmd_sh_q[7:0] <= buf_out_data[7:0]; // R2
                    word_ok_q <= 1'b1;
                end
                else
                begin
                    cmd_sh_q[7:0] <= word_q[15:8]; // R2
                    word_ok_q <= 1'b0;
                end
                hi_sel_q <= ~hi_sel_q; // R2
            end
            if (shift_dr && sel_read)
                cmd_sh_q[7:0] <= {tdi_f_q, cmd_sh_q[7:1]}; // R4
            if (shift_dr && sel_cmd)
                cmd_sh_q <= {tdi_f_q, cmd_sh_q[`JFRPE_CMD_W-1:1]};
            if (shift_dr && sel_unlock)
                unlock_sh_q <= {tdi_f_q, unlock_sh_q[`JFRPE_UNLOCK_W-1:1]};
            if (shift_dr)
                bypass_q <= tdi_f_q;
        end
    end

    // program counter: preset, then post-increment after each high byte
    always @(posedge ref_clk)
    begin
        if (rst)
            pc_q <= {ADDR_W{1'b0}};
        else if (pc_load)
            pc_q <= pc_load_val;
        else if (cap_dr && sel_read && hi_sel_q)
            pc_q <= pc_q + {{(ADDR_W-1){1'b0}}, 1'b1}; // R3
    end
    assign prog_counter = pc_q;

    // reset register: no update stage, the shift bit is the reset itself
    always @(posedge ref_clk)
    begin
        if (tap_rst)
            reset_reg_q <= 1'b0;
        else if (shift_dr && sel_reset)
            reset_reg_q <= tdi_f_q; // R8
    end

    // time-out counter runs after release; length set by the clock fuse
    reg [`JFRPE_TOUT_W-1:0] tout_q;
    always @(posedge ref_clk)
    begin
        if (rst || reset_reg_q)
            tout_q <= clk_fuse_long ? TOUT_LONG_CYC[`JFRPE_TOUT_W-1:0]
                                    : TOUT_SHORT_CYC[`JFRPE_TOUT_W-1:0]; // R7
        else if (tout_q != {`JFRPE_TOUT_W{1'b0}})
            tout_q <= tout_q - {{(`JFRPE_TOUT_W-1){1'b0}}, 1'b1}; // R7
    end
    assign dev_reset = reset_reg_q || (tout_q != {`JFRPE_TOUT_W{1'b0}}); // R6

    // enable register only clears on power-on; tap reset leaves it alone
    always @(posedge ref_clk)
    begin
        if (rst)
            unlock_q <= 16'h0000; // R10
        else if (upd_dr && sel_unlock)
            unlock_q <= unlock_sh_q; // R12
    end
    assign prog_mode = (unlock_q == `JFRPE_UNLOCK_SIG); // R9
    assign active_instr = ir_q;

    // tdo changes on tck falling edge, driven only in shift states
    always @(posedge ref_clk)
    begin
        if (tap_rst)
        begin
            tdo_o <= 1'b0;
            tdo_oe_n <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_oe_n <= !(tap_q == `JFRPE_TAP_SHIFT_DR || tap_q == `JFRPE_TAP_SHIFT_IR);
            if (tap_q == `JFRPE_TAP_SHIFT_IR)
                tdo_o <= ir_sh_q[0];
            else if (sel_read || sel_cmd)
                tdo_o <= cmd_sh_q[0]; // R4
            else if (sel_unlock)
                tdo_o <= unlock_sh_q[0];
            else if (sel_reset)
                tdo_o <= reset_reg_q;
            else
                tdo_o <= bypass_q;
        end
    end
endmodule // jfrpe_core

// file: jfrpe_core_asserts.sv
// Purpose: port-level checks for the flash readback / programming entry block
// Assumes: one ref_clk domain, synchronous active-high rst
// Notes: bound to jfrpe_core from the testbench top
`include "jfrpe_defines.vh"
module jfrpe_core_asserts #(
    parameter ADDR_W = 16,
    parameter TOUT_SHORT_CYC = 20,
    parameter TOUT_LONG_CYC = 40
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // test port
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trst_n,
    input wire tdo_o,
    input wire tdo_oe_n,
    // program counter and flash port
    input wire pc_load,
    input wire [ADDR_W-1:0] pc_load_val,
    input wire [ADDR_W-1:0] prog_counter,
    input wire flash_rd_req,
    input wire [ADDR_W-1:0] flash_rd_addr,
    input wire flash_rd_ack,
    input wire [15:0] flash_rd_data,
    // status
    input wire clk_fuse_long,
    input wire dev_reset,
    input wire prog_mode,
    input wire [3:0] active_instr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    int tout;
    int hi_cnt_q;
    assign tout = clk_fuse_long ? TOUT_LONG_CYC : TOUT_SHORT_CYC;
    // length of the current reset pulse; one cycle of slack for the counter phase
    always @(posedge ref_clk)
    begin
        if (rst || !dev_reset)
            hi_cnt_q <= 0;
        else
            hi_cnt_q <= hi_cnt_q + 1;
    end
    a_req_source: assert property ($rose(flash_rd_req) |-> active_instr == `JFRPE_INSTR_PAGE_READ)
        else $error("flash read requested outside page read");
    a_req_hold: assert property (flash_rd_req && !flash_rd_ack |=> flash_rd_req)
        else $error("flash request dropped before answer");
    a_pc_step: assert property (!pc_load |=> prog_counter == $past(prog_counter)
        || prog_counter == $past(prog_counter) + 1'b1)
        else $error("program counter moved by other than one");
    a_pc_preset: assert property (pc_load |=> prog_counter == $past(pc_load_val))
        else $error("program counter preset not taken");
    a_mode_source: assert property ($changed(prog_mode)
        |-> $past(active_instr) == `JFRPE_INSTR_UNLOCK)
        else $error("programming mode changed outside unlock");
    a_tout_min: assert property ($fell(dev_reset) |-> hi_cnt_q >= tout - 1)
        else $error("device reset released before time-out");
    a_por_clear: assert property ($fell(rst) |-> !prog_mode && prog_counter == '0
        && dev_reset && active_instr == `JFRPE_INSTR_BYPASS && tdo_oe_n)
        else $error("power-on values wrong");
    a_tdo_hold: assert property ($changed(tdo_o) |=> $stable(tdo_o) [*3])
        else $error("tdo moved faster than one bit per tck");
endmodule // jfrpe_core_asserts

// file: jfrpe_flash_model.sv
// Purpose: flash memory answering word reads from the block
// Assumes: lat of at least 1, request held until ack
// Notes: data lines carry the inverted word whenever no answer stands
module jfrpe_flash_model (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // answer delay in cycles
    input wire [3:0] lat,
    // read port
    input wire flash_rd_req,
    input wire [15:0] flash_rd_addr,
    output logic flash_rd_ack,
    output logic [15:0] flash_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    logic [15:0] word;
    assign word = {flash_rd_addr[7:0] ^ 8'ha5, flash_rd_addr[15:8] ^ flash_rd_addr[7:0]};
    // one ack pulse per request; inverted data so a stale capture shows
    always @(posedge ref_clk)
    begin
        flash_rd_ack <= 1'b0;
        flash_rd_data <= ~word;
        if (rst || !flash_rd_req)
            cnt_q <= 4'h0;
        else if (cnt_q >= lat)
        begin
            cnt_q <= 4'h0;
            flash_rd_ack <= 1'b1;
            flash_rd_data <= word;
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule // jfrpe_flash_model

// file: tb_jfrpe_core.sv
// Purpose: self-checking bench for the test-port readback block
// Assumes: tck of 800 ns built from ref_clk edges, tms/tdi change at tck fall
// Notes: reset time-outs shortened to 20 and 40 cycles
`include "jfrpe_defines.vh"
module tb_jfrpe_core;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TS = 20;
    localparam int TL = 40;
    logic ref_clk = 1'b0, rst = 1'b1, tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_n = 1'b1;
    logic pc_load = 1'b0, clk_fuse_long = 1'b0, tdo_o, tdo_oe_n, flash_rd_req, flash_rd_ack;
    logic dev_reset, prog_mode;
    logic [15:0] pc_load_val = 16'h0000, prog_counter, flash_rd_addr, flash_rd_data;
    logic [3:0] active_instr, lat = 4'h1;
    int errors = 0, total_checks = 0, cyc = 0;

    jfrpe_core #(.ADDR_W(16), .TOUT_SHORT_CYC(TS), .TOUT_LONG_CYC(TL)) dut (
        .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .pc_load(pc_load), .pc_load_val(pc_load_val),
        .prog_counter(prog_counter), .flash_rd_req(flash_rd_req),
        .flash_rd_addr(flash_rd_addr), .flash_rd_ack(flash_rd_ack),
        .flash_rd_data(flash_rd_data), .clk_fuse_long(clk_fuse_long),
        .dev_reset(dev_reset), .prog_mode(prog_mode), .active_instr(active_instr));
    jfrpe_flash_model u_flash (.ref_clk(ref_clk), .rst(rst), .lat(lat),
        .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
        .flash_rd_ack(flash_rd_ack), .flash_rd_data(flash_rd_data));

    // 10 MHz reference clock
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] fw(input logic [15:0] a);
        return {a[7:0] ^ 8'ha5, a[15:8] ^ a[7:0]};
    endfunction

    task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            test_done;
        end
    end

    // one tck period: tdo read just after tck goes high, tms/tdi held across it
    task step(input logic m, input logic d, output logic o);
        @(posedge ref_clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b1;
        #1 o = tdo_o;
        repeat (3) @(posedge ref_clk);
    endtask

    // idle to idle through an IR or DR scan, LSB first
    task scan(input logic ir, input logic [15:0] din, input int n, output logic [15:0] dout);
        logic o;
        dout = 16'h0000;
        step(1'b1, 1'b0, o);
        if (ir)
            step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        // the last tck rise reaches the tap one edge later; let it land before looking
        @(posedge ref_clk);
        #1;
    endtask

    // shift one bit into the reset register, stop in exit1 before update
    task rr(input logic v);
        logic o;
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b1, v, o);
    endtask

    task fin;
        logic o;
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    task tout_chk(input int t);
        int c;
        c = 0;
        while (dev_reset === 1'b1 && c < 200)
        begin
            @(posedge ref_clk);
            #1 c = c + 1;
        end
        chk(c >= t - 4 && c <= t + 4, 1'b1, "reset time-out");
    endtask

    task t_por;
        logic o;
        @(posedge ref_clk);
        #1 chk(prog_mode, 1'b0, "prog_mode");
        chk(prog_counter, 16'h0000, "prog_counter");
        chk(active_instr, `JFRPE_INSTR_BYPASS, "active_instr");
        chk(tdo_oe_n, 1'b1, "tdo_oe_n");
        tout_chk(TS);
        step(1'b0, 1'b0, o);
        $display("t_por done");
    endtask

    task t_unlock;
        logic [15:0] d;
        logic o;
        scan(1'b1, `JFRPE_INSTR_RESET, 4, d);
        rr(1'b1);
        fin;
        scan(1'b1, `JFRPE_INSTR_UNLOCK, 4, d);
        scan(1'b0, `JFRPE_UNLOCK_SIG ^ 16'h0001, 16, d);
        chk(prog_mode, 1'b0, "mode, near signature");
        scan(1'b0, `JFRPE_UNLOCK_SIG, 16, d);
        chk(prog_mode, 1'b1, "mode, signature");
        @(posedge ref_clk);
        trst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        trst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk(prog_mode, 1'b1, "mode after test reset");
        step(1'b0, 1'b0, o);
        scan(1'b1, `JFRPE_INSTR_UNLOCK, 4, d);
        scan(1'b0, 16'h0000, 16, d);
        chk(prog_mode, 1'b0, "mode cleared");
        scan(1'b0, `JFRPE_UNLOCK_SIG, 16, d);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1 chk(prog_mode, 1'b0, "mode after power-on");
        tout_chk(TS);
        step(1'b0, 1'b0, o);
        $display("t_unlock done");
    endtask

    task t_reset(input logic fz);
        logic [15:0] d;
        @(posedge ref_clk);
        clk_fuse_long <= fz;
        scan(1'b1, `JFRPE_INSTR_RESET, 4, d);
        chk(dev_reset, 1'b0, "reset idle");
        rr(1'b1);
        repeat (2) @(posedge ref_clk);
        #1 chk(dev_reset, 1'b1, "reset before update");
        fin;
        repeat (60) @(posedge ref_clk);
        #1 chk(dev_reset, 1'b1, "reset held");
        rr(1'b0);
        tout_chk(fz ? TL : TS);
        fin;
        $display("t_reset fuse %0d done", fz);
    endtask

    task t_page;
        logic [15:0] d, a, w;
        @(posedge ref_clk);
        pc_load <= 1'b1;
        pc_load_val <= 16'h003f;
        @(posedge ref_clk);
        pc_load <= 1'b0;
        scan(1'b1, `JFRPE_INSTR_PAGE_READ, 4, d);
        chk(active_instr, `JFRPE_INSTR_PAGE_READ, "active_instr");
        chk(d[3:0], 4'h1, "ir capture");
        // last word of one page into the next; the slow answers land on the third word, 0x41
        for (int k = 0; k < 4; k++)
        begin
            a = 16'h003f + 16'(k / 2);
            w = fw(a);
            lat <= (k < 2) ? 4'h1 : 4'h6;
            scan(1'b0, 16'h0000, 8, d);
            #1 chk(d[7:0], k[0] ? w[15:8] : w[7:0], "page byte");
            chk(prog_counter, a + {15'h0000, k[0]}, "prog_counter");
        end
        // a fresh load starts again on the low byte
        scan(1'b0, 16'h0000, 8, d);
        scan(1'b1, `JFRPE_INSTR_PAGE_READ, 4, d);
        scan(1'b0, 16'h0000, 8, d);
        w = fw(16'h0041);
        #1 chk(d[7:0], w[7:0], "low byte again");
        chk(prog_counter, 16'h0041, "prog_counter held");
        chk(tdo_oe_n, 1'b1, "tdo released");
        $display("t_page done");
    endtask

    // command register: a 15-bit word shifted in comes back out on the next scan
    task t_cmd;
        logic [15:0] d;
        scan(1'b1, `JFRPE_INSTR_CMD_ENTRY, 4, d);
        scan(1'b0, 16'h2b5c, 15, d);
        scan(1'b0, 16'h0000, 15, d);
        #1 chk(d, 16'h2b5c, "command shift");
        $display("t_cmd done");
    endtask

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_por;
        t_unlock;
        t_reset(1'b0);
        t_reset(1'b1);
        t_page;
        t_cmd;
        test_done;
    end
endmodule // tb_jfrpe_core

bind jfrpe_core jfrpe_core_asserts #(.ADDR_W(ADDR_W), .TOUT_SHORT_CYC(TOUT_SHORT_CYC),
    .TOUT_LONG_CYC(TOUT_LONG_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
    .pc_load(pc_load), .pc_load_val(pc_load_val), .prog_counter(prog_counter),
    .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_ack(flash_rd_ack), .flash_rd_data(flash_rd_data),
    .clk_fuse_long(clk_fuse_long), .dev_reset(dev_reset), .prog_mode(prog_mode),
    .active_instr(active_instr));
